// ===== logic/wnba_evt_stat.sv
`timescale 1ns/1ns
`include "wnba_map.svh"
module wnba_evt_stat import wnba_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic [`WNBA_EVT_W-1:0] evt,
  input wire logic clr_we,
  input wire logic mask_we,
  input wire logic [`WNBA_EVT_W-1:0] wdata,
  output logic [`WNBA_EVT_W-1:0] stat,
  output logic [`WNBA_EVT_W-1:0] mask,
  output logic irq
);
  typedef struct packed {
    logic [`WNBA_EVT_W-1:0] stat;
    logic [`WNBA_EVT_W-1:0] mask;
    logic irq;
  } wnba_stat_s;

  wnba_stat_s s_r;
  wnba_stat_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    // The event term is applied after the clear so a coincident event stays.
    if (clr_we) begin
      s_nxt.stat = s_r.stat & ~wdata;
    end
    s_nxt.stat = s_nxt.stat | evt;
    if (mask_we) begin
      s_nxt.mask = wdata;
    end
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign stat = s_r.stat;
  assign mask = s_r.mask;
  assign irq = s_r.irq;

  AST_SET_WINS: assert property (@(posedge clk) disable iff (reset)
    evt[0] |=> stat[0])
    else $error("Status event was lost.");
endmodule

// ===== logic/wnba_map.svh
// Overview of operation
// - Host 16-bit accesses become 8-bit module cycles with word address.
// - A module non-maskable request is forwarded on one of seven levels.
// - The module request input follows one of seven host levels.
// - An option decides if the acknowledge chain input passes through.
// - The module phase clock runs at 1 MHz or 2 MHz, 1 MHz by default.
// - An acknowledged interrupt returns a configurable vector.
// - Module data sit on the upper or lower host byte, upper by default.
// - The block selects itself by matching A23..A08 to a switch value.
// - Each of address lines A15..A08 can be left out of the match.
// - By default the block answers at 128 bytes from 800000 to 8000FF.
// - Paired adapters share address and phase clock for 16-bit moves.
// - Module control lines are generated aligned to the phase clock.
`ifndef WNBA_MAP_SVH
`define WNBA_MAP_SVH
`define WNBA_CLK_NS 50
`define WNBA_E1M_NS 1000
`define WNBA_E2M_NS 500
`define WNBA_HALF_1M ((`WNBA_E1M_NS / 2) / `WNBA_CLK_NS)
`define WNBA_HALF_2M ((`WNBA_E2M_NS / 2) / `WNBA_CLK_NS)
`define WNBA_OFF_CTRL 8'h00
`define WNBA_OFF_DEC 8'h04
`define WNBA_OFF_VIRQ 8'h08
`define WNBA_OFF_VNMI 8'h0C
`define WNBA_OFF_STAT 8'h10
`define WNBA_OFF_MASK 8'h14
`define WNBA_OFF_STATE 8'h18
`define WNBA_CTRL_W 15
`define WNBA_DEC_MATCH 0
`define WNBA_DEC_DC 16
`define WNBA_RST_CTRL 32'h0000_7713
`define WNBA_RST_MATCH 16'h8000
`define WNBA_RST_DC 8'h00
`define WNBA_RST_VIRQ 24'h00_0064
`define WNBA_RST_VNMI 24'h00_007C
`define WNBA_EVT_NMI 0
`define WNBA_EVT_DONE 1
`define WNBA_EVT_VEC 2
`define WNBA_EVT_W 3
`endif

// ===== logic/wnba_phase_div.sv
`timescale 1ns/1ns
`include "wnba_map.svh"
module wnba_phase_div import wnba_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic sel_2m,
  input wire logic follow,
  input wire logic ext_phase,
  output logic phase,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic [3:0] cnt;
    logic sel;
    logic ph;
    logic rise;
    logic fall;
  } wnba_div_s;

  wnba_div_s s_r;
  wnba_div_s s_nxt;
  logic [3:0] lim;

  always_comb begin
    lim = s_r.sel ? 4'(`WNBA_HALF_2M - 1) : 4'(`WNBA_HALF_1M - 1);
    s_nxt = s_r;
    // A follower takes the partner's phase so both module cycles line up.
    if (follow) begin
      s_nxt.ph = ext_phase;
      s_nxt.cnt = 4'h0;
      s_nxt.sel = sel_2m;
    end else if (s_r.cnt >= lim) begin
      s_nxt.cnt = 4'h0;
      s_nxt.ph = ~s_r.ph;
      // Unless following, the rate is taken only at a toggle, so no half period is cut short.
      s_nxt.sel = sel_2m;
    end else begin
      s_nxt.cnt = s_r.cnt + 4'h1;
    end
    s_nxt.rise = s_nxt.ph & ~s_r.ph;
    s_nxt.fall = ~s_nxt.ph & s_r.ph;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign phase = s_r.ph;
  assign rise = s_r.rise;
  assign fall = s_r.fall;

  AST_E2M_HIGH: assert property (@(posedge clk) disable iff (reset)
    ($rose(phase) && s_r.sel && !follow) |-> phase[*5] ##1 !phase)
    else $error("2 MHz phase high time is not five cycles.");
  AST_E1M_HIGH: assert property (@(posedge clk) disable iff (reset)
    ($rose(phase) && !s_r.sel && !follow) |->
    phase[*8] ##1 phase[*2] ##1 !phase)
    else $error("1 MHz phase high time is not ten cycles.");
endmodule

// ===== logic/wnba_pkg.sv
package wnba_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SYNC = 3'h1,
    ST_ADDR = 3'h3,
    ST_DATA = 3'h2,
    ST_DONE = 3'h6,
    ST_VEC = 3'h7
  } wnba_state_e;

  typedef struct packed {
    logic [2:0] irq_lvl;
    logic rsv_b;
    logic [2:0] nmi_lvl;
    logic [2:0] rsv_a;
    logic pair_master;
    logic pair;
    logic clk_2m;
    logic ack_pass;
    logic upper;
  } wnba_cfg_s;

  typedef struct packed {
    logic [23:0] addr;
    logic write;
    logic [15:0] wdata;
  } wnba_hreq_s;

  typedef struct packed {
    logic [15:0] addr;
    logic rd;
    logic vma;
    logic [7:0] wdata;
    logic oe_n;
  } wnba_mbus_s;
endpackage

// ===== logic/wnba_top.sv
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns
`include "wnba_map.svh"
module wnba_top import wnba_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic host_req,
  input wire logic [23:0] host_addr,
  input wire logic host_write,
  input wire logic [15:0] host_wdata,
  input wire logic host_iack,
  input wire logic [2:0] host_iack_lvl,
  input wire logic ack_chain_in,
  input wire logic [7:1] host_irq_in,
  output logic host_ack,
  output logic [15:0] host_rdata,
  output logic [1:0] host_lane_en,
  output logic [7:1] host_irq_out,
  output logic ack_chain_out,
  output logic mod_phase,
  output wnba_mbus_s mod_bus,
  input wire logic [7:0] mod_rdata,
  input wire logic mod_nmi,
  output logic mod_irq,
  input wire logic pair_phase_in
);
  typedef struct packed {
    wnba_state_e st;
    wnba_hreq_s hreq;
    wnba_mbus_s mb;
    logic ack;
    logic [15:0] rdata;
    logic [1:0] lane;
    logic [6:0] irq_out;
    logic chain;
    logic mirq;
    logic nmi_q;
    wnba_cfg_s cfg;
    logic [15:0] match;
    logic [7:0] dc;
    logic [23:0] vec_irq;
    logic [23:0] vec_nmi;
    logic ap_we;
    logic [7:0] ap_addr;
    logic [31:0] hrdata;
    logic hready;
  } wnba_top_s;

  localparam wnba_cfg_s CFG_RST = wnba_cfg_s'(15'(`WNBA_RST_CTRL));

  wnba_top_s s_r;
  wnba_top_s s_nxt;
  logic ph_rise;
  logic ph_fall;
  logic hit;
  logic nmi_hit;
  logic irq_hit;
  logic ap;
  logic [7:0] lane_byte;
  logic [`WNBA_EVT_W-1:0] evt;
  logic [`WNBA_EVT_W-1:0] stat_q;
  logic [`WNBA_EVT_W-1:0] mask_q;
  logic stat_we;
  logic mask_we;

  function automatic logic [6:0] lvl_sel(input logic [2:0] lvl);
    lvl_sel = (lvl == 3'h0) ? 7'h00 : 7'(7'h01 << (lvl - 3'h1));
  endfunction

  function automatic logic addr_hit(input logic [23:0] a,
                                    input logic [15:0] m,
                                    input logic [7:0] dc,
                                    input wnba_cfg_s c);
    logic top_ok;
    logic mid_ok;
    logic lsb_ok;
    top_ok = (a[23:16] == m[15:8]);
    mid_ok = (((a[15:8] ^ m[7:0]) & ~dc) == 8'h00);
    // Only the chosen byte lane answers alone, hence 128 of 256 bytes.
    lsb_ok = c.pair | (a[0] == ~c.upper);
    addr_hit = top_ok & mid_ok & lsb_ok;
  endfunction

  function automatic wnba_cfg_s cfg_from(input logic [31:0] w);
    wnba_cfg_s c;
    c = wnba_cfg_s'(w[`WNBA_CTRL_W-1:0]);
    c.rsv_a = 3'h0;
    c.rsv_b = 1'b0;
    cfg_from = c;
  endfunction

  wnba_phase_div u_div (
    .clk(clk),
    .reset(reset),
    .sel_2m(s_r.cfg.clk_2m),
    .follow(s_r.cfg.pair & ~s_r.cfg.pair_master),
    .ext_phase(pair_phase_in),
    .phase(mod_phase),
    .rise(ph_rise),
    .fall(ph_fall)
  );

  wnba_evt_stat u_stat (
    .clk(clk),
    .reset(reset),
    .evt(evt),
    .clr_we(stat_we),
    .mask_we(mask_we),
    .wdata(hwdata[`WNBA_EVT_W-1:0]),
    .stat(stat_q),
    .mask(mask_q),
    .irq(irq)
  );

  always_comb begin
    s_nxt = s_r;
    evt = '0;
    hit = addr_hit(host_addr, s_r.match, s_r.dc, s_r.cfg);
    nmi_hit = mod_nmi && (s_r.cfg.nmi_lvl != 3'h0) &&
              (host_iack_lvl == s_r.cfg.nmi_lvl);
    irq_hit = s_r.mirq && (host_iack_lvl == s_r.cfg.irq_lvl);
    lane_byte = s_r.cfg.upper ? s_r.hreq.wdata[15:8] :
                s_r.hreq.wdata[7:0];
    ap = hsel && hready && htrans[1];
    stat_we = s_r.ap_we && (s_r.ap_addr == `WNBA_OFF_STAT);
    mask_we = s_r.ap_we && (s_r.ap_addr == `WNBA_OFF_MASK);

    // Register bus: address phase captured, write applied in data phase.
    s_nxt.hready = 1'b1;
    s_nxt.ap_we = ap && hwrite && (haddr[31:8] == 24'h00_0000);
    s_nxt.ap_addr = haddr[7:0];
    s_nxt.hrdata = 32'h0000_0000;
    if (ap && !hwrite && (haddr[31:8] == 24'h00_0000)) begin
      case (haddr[7:0])
        `WNBA_OFF_CTRL: s_nxt.hrdata = 32'(s_r.cfg);
        `WNBA_OFF_DEC: s_nxt.hrdata = {8'h00, s_r.dc, s_r.match};
        `WNBA_OFF_VIRQ: s_nxt.hrdata = {8'h00, s_r.vec_irq};
        `WNBA_OFF_VNMI: s_nxt.hrdata = {8'h00, s_r.vec_nmi};
        `WNBA_OFF_STAT: s_nxt.hrdata = 32'(stat_q);
        `WNBA_OFF_MASK: s_nxt.hrdata = 32'(mask_q);
        `WNBA_OFF_STATE: s_nxt.hrdata = {24'h00_0000, s_r.mirq, s_r.nmi_q,
                                         mod_phase, s_r.ack, 1'b0, s_r.st};
        default: s_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    if (s_r.ap_we) begin
      case (s_r.ap_addr)
        `WNBA_OFF_CTRL: s_nxt.cfg = cfg_from(hwdata);
        `WNBA_OFF_DEC: begin
          s_nxt.match = hwdata[`WNBA_DEC_MATCH +: 16];
          s_nxt.dc = hwdata[`WNBA_DEC_DC +: 8];
        end
        `WNBA_OFF_VIRQ: s_nxt.vec_irq = hwdata[23:0];
        `WNBA_OFF_VNMI: s_nxt.vec_nmi = hwdata[23:0];
        default: s_nxt.cfg = s_r.cfg;
      endcase
    end

    // Interrupt routing between the two buses.
    s_nxt.nmi_q = mod_nmi;
    evt[`WNBA_EVT_NMI] = mod_nmi & ~s_r.nmi_q;
    s_nxt.irq_out = mod_nmi ? lvl_sel(s_r.cfg.nmi_lvl) : 7'h00;
    s_nxt.mirq = |(host_irq_in & lvl_sel(s_r.cfg.irq_lvl));
    // A claimed acknowledge never travels on down the chain.
    s_nxt.chain = host_iack && ack_chain_in && s_r.cfg.ack_pass &&
                  !nmi_hit && !irq_hit && (s_r.st != ST_VEC);

    case (s_r.st)
      ST_IDLE: begin
        if (host_iack && ack_chain_in && (nmi_hit || irq_hit)) begin
          s_nxt.st = ST_VEC;
          s_nxt.ack = 1'b1;
          s_nxt.lane = 2'h3;
          // The non-maskable path has priority when both levels match.
          s_nxt.rdata = nmi_hit ? s_r.vec_nmi[15:0] :
                        s_r.vec_irq[15:0];
          evt[`WNBA_EVT_VEC] = 1'b1;
        end else if (host_req && !host_iack && hit) begin
          s_nxt.st = ST_SYNC;
          s_nxt.hreq.addr = host_addr;
          s_nxt.hreq.write = host_write;
          s_nxt.hreq.wdata = host_wdata;
        end
      end
      ST_SYNC: begin
        // Waiting for a falling phase keeps the module setup time intact.
        if (ph_fall) begin
          s_nxt.st = ST_ADDR;
          s_nxt.mb.vma = 1'b1;
          s_nxt.mb.addr = s_r.hreq.addr[16:1];
          s_nxt.mb.rd = ~s_r.hreq.write;
        end
      end
      ST_ADDR: begin
        if (ph_rise) begin
          s_nxt.st = ST_DATA;
          if (s_r.hreq.write) begin
            s_nxt.mb.wdata = lane_byte;
            s_nxt.mb.oe_n = 1'b0;
          end
        end
      end
      ST_DATA: begin
        if (ph_fall) begin
          s_nxt.st = ST_DONE;
          s_nxt.ack = 1'b1;
          s_nxt.mb.vma = 1'b0;
          s_nxt.mb.oe_n = 1'b1;
          s_nxt.lane = s_r.cfg.upper ? 2'h2 : 2'h1;
          if (s_r.hreq.write) begin
            s_nxt.rdata = 16'h0000;
          end else if (s_r.cfg.upper) begin
            s_nxt.rdata = {mod_rdata, 8'h00};
          end else begin
            s_nxt.rdata = {8'h00, mod_rdata};
          end
          evt[`WNBA_EVT_DONE] = 1'b1;
        end
      end
      ST_DONE, ST_VEC: begin
        if (!host_req && !host_iack) begin
          s_nxt.st = ST_IDLE;
          s_nxt.ack = 1'b0;
          s_nxt.lane = 2'h0;
          s_nxt.rdata = 16'h0000;
        end
      end
      default: begin
        s_nxt.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.mb.oe_n <= 1'b1;
      s_r.cfg <= CFG_RST;
      s_r.match <= `WNBA_RST_MATCH;
      s_r.dc <= `WNBA_RST_DC;
      s_r.vec_irq <= `WNBA_RST_VIRQ;
      s_r.vec_nmi <= `WNBA_RST_VNMI;
      s_r.hready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hrdata = s_r.hrdata;
  assign hreadyout = s_r.hready;
  assign hresp = 1'b0;
  assign host_ack = s_r.ack;
  assign host_rdata = s_r.rdata;
  assign host_lane_en = s_r.lane;
  assign host_irq_out = s_r.irq_out;
  assign ack_chain_out = s_r.chain;
  assign mod_bus = s_r.mb;
  assign mod_irq = s_r.mirq;

  AST_MISS_IGNORED: assert property (@(posedge clk) disable iff (reset)
    (s_r.st == ST_IDLE && host_req && !host_iack && !hit) |=>
    (s_r.st == ST_IDLE && !host_ack))
    else $error("An unmatched access was taken.");
  AST_ACK_ON_FALL: assert property (@(posedge clk) disable iff (reset)
    (s_r.st == ST_DATA && ph_fall) |=> (host_ack && s_r.st == ST_DONE))
    else $error("Host ack did not follow the module cycle end.");
  AST_VMA_LOW_PHASE: assert property (@(posedge clk) disable iff (reset)
    $rose(mod_bus.vma) |-> (!mod_phase && $past(ph_fall)))
    else $error("Module cycle did not start at a phase fall.");
  AST_MADDR: assert property (@(posedge clk) disable iff (reset)
    mod_bus.vma |-> (mod_bus.addr == s_r.hreq.addr[16:1]))
    else $error("Module address is not the host word address.");
  AST_WDATA_LANE: assert property (@(posedge clk) disable iff (reset)
    (s_r.st == ST_DATA && !mod_bus.oe_n) |-> (mod_bus.wdata ==
    (s_r.cfg.upper ? s_r.hreq.wdata[15:8] : s_r.hreq.wdata[7:0])))
    else $error("Module write data came from the wrong lane.");
  AST_NMI_FWD: assert property (@(posedge clk) disable iff (reset)
    (mod_nmi && s_r.cfg.nmi_lvl == 3'h7 && !s_r.ap_we) |=> host_irq_out[7])
    else $error("Module NMI was not forwarded on level 7.");
  AST_NMI_ONE: assert property (@(posedge clk) disable iff (reset)
    $onehot0(host_irq_out))
    else $error("More than one host level is requested.");
  AST_IRQ_IN: assert property (@(posedge clk) disable iff (reset)
    (host_irq_in[7] && s_r.cfg.irq_lvl == 3'h7 && !s_r.ap_we) |=> mod_irq)
    else $error("Host level 7 did not reach the module.");
  AST_CHAIN_BLOCK: assert property (@(posedge clk) disable iff (reset)
    !s_r.cfg.ack_pass |=> !ack_chain_out)
    else $error("Acknowledge chain passed while blocked.");
  AST_VEC: assert property (@(posedge clk) disable iff (reset)
    (s_r.st == ST_VEC) |-> (host_ack && (host_rdata == s_r.vec_nmi[15:0] ||
    host_rdata == s_r.vec_irq[15:0])))
    else $error("Acknowledge returned a wrong vector.");
  AST_LANE: assert property (@(posedge clk) disable iff (reset)
    (s_r.st == ST_DONE && !s_r.ap_we) |->
    (host_lane_en == (s_r.cfg.upper ? 2'h2 : 2'h1)))
    else $error("Read data placed on the wrong lane.");
endmodule

// ===== test/test_wnba_top.sv
`timescale 1ns/1ns
`include "wnba_map.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module test_wnba_top;
  import wnba_pkg::*;
  logic clk, reset, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] host_iack_lvl;
  logic host_req, host_write, host_iack, ack_chain_in, host_ack;
  logic ack_chain_out, mod_phase, mod_nmi, mod_irq, nmi_cmd, dp_rd, ack_d;
  logic [23:0] host_addr;
  logic [15:0] host_wdata;
  logic [15:0] host_rdata;
  logic [7:1] host_irq_in;
  logic [7:1] host_irq_out;
  logic [1:0] host_lane_en;
  wnba_mbus_s mod_bus;
  logic [7:0] mod_rdata;
  logic [7:0] rnd;
  logic [7:0] b;
  logic [23:0] a;
  logic [63:0] aq[$];
  logic [35:0] hq[$];
  logic [63:0] ae;
  logic [35:0] he;
  logic [31:0] ra [6] = '{32'h00, 32'h04, 32'h08, 32'h0C, 32'h14, 32'h100};
  logic [31:0] rv [6] = '{32'h7713, 32'h8000, 32'h64, 32'h7C, 32'h0, 32'h0};
  int err_total;
  int n_compared;

  wnba_top wnba_top_i (.clk(clk), .reset(reset), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .host_req(host_req), .host_addr(host_addr), .host_write(host_write),
    .host_wdata(host_wdata), .host_iack(host_iack),
    .host_iack_lvl(host_iack_lvl), .ack_chain_in(ack_chain_in),
    .host_irq_in(host_irq_in), .host_ack(host_ack),
    .host_rdata(host_rdata), .host_lane_en(host_lane_en),
    .host_irq_out(host_irq_out), .ack_chain_out(ack_chain_out),
    .mod_phase(mod_phase), .mod_bus(mod_bus), .mod_rdata(mod_rdata),
    .mod_nmi(mod_nmi), .mod_irq(mod_irq), .pair_phase_in(mod_phase));
  wnba_mod_model wnba_mod_model_i (.clk(clk), .bus(mod_bus),
    .nmi_cmd(nmi_cmd), .rdata(mod_rdata), .nmi(mod_nmi));
  // The one slave's ready is the bus's ready.
  assign hready = hreadyout;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic ahb(input logic w, input logic [31:0] ad, d, m);
    int k;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= ad;
    hwrite <= w;
    htrans <= 2'h2;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    if (!w) begin
      aq.push_back({m, d});
      dp_rd <= 1'b1;
    end
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hready !== 1'b1 && k < 50);
    dp_rd <= 1'b0;
  endtask

  task automatic host(input logic ia, w, input logic [23:0] ad,
      input logic [15:0] d, input logic [17:0] m, e);
    int k;
    hq.push_back({m, e});
    @(posedge clk);
    host_req <= !ia;
    host_iack <= ia;
    ack_chain_in <= ia;
    host_iack_lvl <= ad[2:0];
    host_addr <= ad;
    host_write <= w;
    host_wdata <= d;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (host_ack !== 1'b1 && k < 100);
    if (k >= 100) begin
      err_total++;
      $display("wrong value at %0t: no host answer", $time);
    end
    host_req <= 1'b0;
    host_iack <= 1'b0;
    ack_chain_in <= 1'b0;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (host_ack !== 1'b0 && k < 20);
  endtask

  task automatic half(input int exp);
    int k;
    k = 0;
    while (mod_phase !== 1'b0 && k < 100) begin
      @(posedge clk);
      k++;
    end
    while (mod_phase !== 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    k = 0;
    while (mod_phase === 1'b1 && k < 100) begin
      @(posedge clk);
      k++;
    end
    `CHK(k, exp)
  endtask

  // Results are judged here, apart from the drivers that noted them.
  always @(posedge clk) begin
    ack_d <= host_ack;
    if (dp_rd === 1'b1 && aq.size() > 0) begin
      ae = aq.pop_front();
      `CHK(hrdata & ae[63:32], ae[31:0])
      `CHK(hresp, 1'b0)
    end
    if (host_ack === 1'b1 && ack_d !== 1'b1 && hq.size() > 0) begin
      he = hq.pop_front();
      `CHK({host_lane_en, host_rdata} & he[35:18], he[17:0])
    end
  end

  task final_report;
    $display("compared %0d, wrong %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #(50 * 20000);
    err_total++;
    final_report;
  end

  initial begin
    {hsel, hwrite, host_req, host_write, host_iack, ack_chain_in} = '0;
    {haddr, hwdata, htrans, host_addr, host_wdata, host_iack_lvl} = '0;
    {host_irq_in, nmi_cmd, dp_rd, ack_d} = '0;
    hsize = 3'h2;
    reset = 1'b1;
    rnd = 8'h15;
    err_total = 0;
    n_compared = 0;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    foreach (ra[i]) ahb(1'b0, ra[i], rv[i], '1);
    // Random bytes through the default window, upper lane.
    for (int i = 0; i < 4; i++) begin
      rnd = lfsr(rnd);
      a = {16'h8000, rnd[6:0], 1'b0};
      rnd = lfsr(rnd);
      b = rnd;
      host(1'b0, 1'b1, a, {b, ~b}, 18'h0FFFF, 18'h0);
      host(1'b0, 1'b0, a, 16'h0, '1, {2'b10, b, 8'h00});
    end
    host_req <= 1'b1;
    host_addr <= 24'h81_0000;
    repeat (60) @(posedge clk);
    `CHK(host_ack, 1'b0)
    host_req <= 1'b0;
    ahb(1'b1, 32'h04, 32'h0001_8000, '0);
    host(1'b0, 1'b1, 24'h80_0102, {b, 8'h5A}, 18'h0FFFF, 18'h0);
    host(1'b0, 1'b0, 24'h80_0102, 16'h0, '1, {2'b10, b, 8'h00});
    ahb(1'b1, 32'h04, 32'h0000_8000, '0);
    ahb(1'b1, 32'h00, 32'h0000_7712, '0);
    host(1'b0, 1'b1, 24'h80_0011, {8'hC3, b}, 18'h0FFFF, 18'h0);
    host(1'b0, 1'b0, 24'h80_0011, 16'h0, '1, {2'b01, 8'h00, b});
    half(`WNBA_HALF_1M);
    ahb(1'b1, 32'h00, 32'h0000_7717, '0);
    half(`WNBA_HALF_2M);
    host(1'b0, 1'b0, 24'h80_0010, 16'h0, '1, {2'b10, b, 8'h00});
    // Paired master: the odd address is taken as well, its byte on the upper lane.
    ahb(1'b1, 32'h00, 32'h0000_771F, '0);
    host(1'b0, 1'b0, 24'h80_0011, 16'h0, '1, {2'b10, b, 8'h00});
    ahb(1'b1, 32'h00, 32'h0000_7713, '0);
    nmi_cmd <= 1'b1;
    repeat (4) @(posedge clk);
    `CHK(host_irq_out, 7'h40)
    `CHK(irq, 1'b0)
    ahb(1'b0, 32'h10, 32'h1, 32'h1);
    ahb(1'b1, 32'h14, 32'h1, '0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    host(1'b1, 1'b0, 24'h7, 16'h0, '1, {2'b11, 16'h007C});
    ahb(1'b1, 32'h10, 32'h1, '0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    ahb(1'b1, 32'h00, 32'h0000_7313, '0);
    repeat (3) @(posedge clk);
    `CHK(host_irq_out, 7'h04)
    nmi_cmd <= 1'b0;
    ahb(1'b1, 32'h00, 32'h0000_7713, '0);
    host_irq_in <= 7'h40;
    repeat (3) @(posedge clk);
    `CHK(mod_irq, 1'b1)
    host(1'b1, 1'b0, 24'h7, 16'h0, '1, {2'b11, 16'h0064});
    host_irq_in <= 7'h20;
    repeat (3) @(posedge clk);
    `CHK(mod_irq, 1'b0)
    host_iack <= 1'b1;
    host_iack_lvl <= 3'h2;
    ack_chain_in <= 1'b1;
    repeat (3) @(posedge clk);
    `CHK(ack_chain_out, 1'b1)
    ahb(1'b1, 32'h00, 32'h0000_7711, '0);
    repeat (3) @(posedge clk);
    `CHK(ack_chain_out, 1'b0)
    host_iack <= 1'b0;
    ack_chain_in <= 1'b0;
    repeat (4) @(posedge clk);
    final_report;
  end
endmodule

// ===== test/wnba_mod_model.sv
`timescale 1ns/1ns
module wnba_mod_model import wnba_pkg::*; (
  input wire logic clk,
  input wire wnba_mbus_s bus,
  input wire logic nmi_cmd,
  output logic [7:0] rdata,
  output logic nmi
);
  logic [7:0] mem [0:255];
  logic [7:0] last_r;
  initial begin
    last_r = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'h00;
    end
  end
  // A write lands only while strobe and driven data stand together.
  always @(posedge clk) begin
    if (bus.vma && !bus.rd && !bus.oe_n) begin
      mem[bus.addr[7:0]] <= bus.wdata;
    end
    last_r <= rdata;
  end
  // Outside a read the lines toggle, so a late sample shows up.
  assign rdata = (bus.vma && bus.rd) ? mem[bus.addr[7:0]] : ~last_r;
  assign nmi = nmi_cmd;
endmodule
